// >>> hw/rcf_pkg.sv
`default_nettype none
package rcf_pkg;
  // clock and sub-clock timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SUB_PERIOD_NS = 31250;
  localparam int TICK_CYCLES   = SUB_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 12;

  // register byte offsets
  localparam logic [7:0] OFS_FLAGS     = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h0C;
  localparam logic [7:0] OFS_WIDTH_SEL = 8'h10;
  localparam logic [7:0] OFS_STATE     = 8'h14;

  // flag bit positions
  localparam int FLAG_W    = 4;
  localparam int BIT_WDOG  = 0;
  localparam int BIT_VSEL  = 1;
  localparam int BIT_LOWV  = 2;
  localparam int BIT_RCTRL = 3;

  // reset values
  localparam logic [3:0] FLAGS_RST     = 4'h0;
  localparam logic [3:0] IRQ_EN_RST    = 4'h0;
  localparam logic [1:0] WIDTH_SEL_RST = 2'h1;

  // defined control codes
  localparam logic [7:0] VSEL_1V7  = 8'h66;
  localparam logic [7:0] VSEL_1V9  = 8'h55;
  localparam logic [7:0] VSEL_2V55 = 8'h33;
  localparam logic [7:0] VSEL_3V15 = 8'h99;
  localparam logic [7:0] VSEL_3V8  = 8'hAA;
  localparam logic [7:0] VSEL_OFF  = 8'hF0;
  localparam logic [7:0] RCTL_IO   = 8'h55;
  localparam logic [7:0] RCTL_PIN  = 8'hAA;

  // dip width limits in sub-clock ticks
  localparam logic [7:0] DIP_8   = 8'h08;
  localparam logic [7:0] DIP_32  = 8'h20;
  localparam logic [7:0] DIP_64  = 8'h40;
  localparam logic [7:0] DIP_128 = 8'h80;

  // reset-cause inputs from the control registers and watchdog
  typedef struct packed {
    logic [7:0] voltageSelectCtrl;
    logic [7:0] resetFunctionCtrl;
    logic       watchdogCorrupt;
  } rcf_cause_t;

  // register-side state of the top module
  typedef struct packed {
    logic [1:0]  lowSync;
    logic [3:0]  flags;
    logic [3:0]  irqStat;
    logic [3:0]  irqEn;
    logic [1:0]  widthSel;
    logic        vselBadPrev;
    logic        rctlBadPrev;
    logic        resetReq;
    logic        ack;
    logic [31:0] rdata;
  } rcf_top_t;

  function automatic logic vselValid(input logic [7:0] v);
    return (v == VSEL_1V7) || (v == VSEL_1V9) || (v == VSEL_2V55) ||
           (v == VSEL_3V15) || (v == VSEL_3V8) || (v == VSEL_OFF);
  endfunction

  function automatic logic rctlValid(input logic [7:0] v);
    return (v == RCTL_IO) || (v == RCTL_PIN);
  endfunction

  function automatic logic [7:0] dipLimit(input logic [1:0] sel);
    case (sel)
      2'h0:    return DIP_8;
      2'h1:    return DIP_32;
      2'h2:    return DIP_64;
      default: return DIP_128;
    endcase
  endfunction
endpackage
`default_nettype wire

// >>> hw/rcf_tick_div.sv
`timescale 1ns/1ns
`default_nettype none
module rcf_tick_div (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // sub-clock enable
  output logic      subTick
);
  typedef struct packed {
    logic [rcf_pkg::TICK_W-1:0] cnt;
    logic                       tick;
  } rcf_div_t;

  rcf_div_t q, d;

  // count down one sub-clock period, then pulse for a cycle
  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (q.cnt == '0) begin
      d.cnt  = rcf_pkg::TICK_W'(rcf_pkg::TICK_CYCLES - 1);
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign subTick = q.tick;
endmodule
`default_nettype wire

// >>> hw/rcf_dip_filter.sv
`timescale 1ns/1ns
`default_nettype none
module rcf_dip_filter (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // supply level, already synchronised
  input  wire logic       supplyLow,
  input  wire logic       monitorEn,
  input  wire logic       subTick,
  input  wire logic [1:0] widthSel,
  // accepted low-supply event
  output logic            dipAccepted,
  output logic [7:0]      dipCount
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       fired;
    logic       pulse;
  } rcf_flt_t;

  rcf_flt_t q, d;

  // ticks are counted while low; a dip shorter than the limit is dropped
  always_comb begin
    d       = q;
    d.pulse = 1'b0;
    if (!supplyLow || !monitorEn) begin
      d.cnt   = '0; // short dip forgotten
      d.fired = 1'b0;
    end else if (subTick && !q.fired) begin
      if (q.cnt + 8'h01 >= rcf_pkg::dipLimit(widthSel)) begin
        d.pulse = 1'b1; // tick count reached the limit
        d.fired = 1'b1;
      end
      d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dipAccepted = q.pulse;
  assign dipCount    = q.cnt;
endmodule
`default_nettype wire

// >>> hw/rcf_reset_flags.sv
// Overview of operation
// - low supply reset sets bit two, sticky
// - bad voltage-select code sets bit one
// - bit one cleared only by writing zero
// - bit zero records watchdog control corruption
// - bad reset-function code sets bit three
// - only dips longer than width count
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module rcf_reset_flags (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,

  // avalon-mm slave
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,

  // reset causes
  input  wire logic                lowSupplyPin,
  input  wire rcf_pkg::rcf_cause_t cause,

  // outputs to the reset generator and cpu
  output logic                     resetRequest,
  output logic [3:0]               resetCauseFlags,
  output logic                     irq
);

  rcf_pkg::rcf_top_t q, d;

  // helper signals
  logic       subTick;
  logic       dipAccepted;
  logic [7:0] dipCount;
  logic       monitorEn;
  logic       vselBad;
  logic       rctlBad;
  logic       busReq;
  logic       busDone;
  logic       wrDone;
  logic       lowByte;
  logic [3:0] setMask;
  logic [3:0] clrMask;
  logic [3:0] irqClr;

  // sub-clock enable for the dip width count
  rcf_tick_div u_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .subTick  (subTick)
  );

  // dip filter watches the second synchroniser stage only
  rcf_dip_filter u_flt (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .supplyLow   (q.lowSync[1]),
    .monitorEn   (monitorEn),
    .subTick     (subTick),
    .widthSel    (q.widthSel),
    .dipAccepted (dipAccepted),
    .dipCount    (dipCount)
  );

  // control-register code checks
  assign vselBad = !rcf_pkg::vselValid(cause.voltageSelectCtrl);
  assign rctlBad = !rcf_pkg::rctlValid(cause.resetFunctionCtrl);

  // monitor idles when switched off or while its code is corrupt
  assign monitorEn = !vselBad && (cause.voltageSelectCtrl != rcf_pkg::VSEL_OFF);

  // bus handshake: one wait cycle, then the answer
  assign busReq  = avs_read || avs_write;
  assign busDone = busReq && q.ack;
  assign wrDone  = avs_write && q.ack;
  assign lowByte = avs_byteenable[0];

  // events that set flags this cycle
  always_comb begin
    setMask                      = 4'h0;
    setMask[rcf_pkg::BIT_LOWV]   = dipAccepted;
    setMask[rcf_pkg::BIT_VSEL]   = vselBad;
    setMask[rcf_pkg::BIT_WDOG]   = cause.watchdogCorrupt;
    setMask[rcf_pkg::BIT_RCTRL]  = rctlBad;
  end

  // software clears a flag by writing zero; ones are ignored
  always_comb begin
    clrMask = 4'h0;
    if (wrDone && lowByte && avs_address == rcf_pkg::OFS_FLAGS) begin
      clrMask = ~avs_writedata[3:0]; // upper bits dropped
    end
  end

  // write-one-to-clear of interrupt status
  always_comb begin
    irqClr = 4'h0;
    if (wrDone && lowByte && avs_address == rcf_pkg::OFS_IRQ_CLR) begin
      irqClr = avs_writedata[3:0];
    end
  end

  // next state of all registers
  always_comb begin
    d = q;

    // two-stage synchroniser on the supply comparator
    d.lowSync[0] = lowSupplyPin;
    d.lowSync[1] = q.lowSync[0];

    // set beats clear so an event is never lost
    d.flags = (q.flags & ~clrMask) | setMask;

    // the two code-check causes raise interrupts on their leading edge only; watchdog and dip set status every cycle they are high
    d.vselBadPrev = vselBad;
    d.rctlBadPrev = rctlBad;
    d.irqStat = (q.irqStat & ~irqClr);
    d.irqStat[rcf_pkg::BIT_LOWV]  = d.irqStat[rcf_pkg::BIT_LOWV] | dipAccepted;
    d.irqStat[rcf_pkg::BIT_VSEL]  = d.irqStat[rcf_pkg::BIT_VSEL] | (vselBad & ~q.vselBadPrev);
    d.irqStat[rcf_pkg::BIT_WDOG]  = d.irqStat[rcf_pkg::BIT_WDOG] | cause.watchdogCorrupt;
    d.irqStat[rcf_pkg::BIT_RCTRL] = d.irqStat[rcf_pkg::BIT_RCTRL] | (rctlBad & ~q.rctlBadPrev);

    // reset request follows any active cause, whether new or already flagged
    d.resetReq = (|setMask) && ((setMask & ~q.flags) != 4'h0 || dipAccepted ||
                 cause.watchdogCorrupt || vselBad || rctlBad);

    // enable and width select writes
    if (wrDone && lowByte) begin
      case (avs_address)
        rcf_pkg::OFS_IRQ_EN: begin
          d.irqEn = avs_writedata[3:0];
        end
        rcf_pkg::OFS_WIDTH_SEL: begin
          d.widthSel = avs_writedata[1:0];
        end
        default: begin
          d.irqEn = q.irqEn;
        end
      endcase
    end

    // handshake: ack high in the second cycle of a request
    d.ack = busReq && !q.ack;

    // read data captured in the wait cycle
    d.rdata = 32'h0000_0000;
    if (avs_read && !q.ack) begin
      case (avs_address)
        rcf_pkg::OFS_FLAGS: begin
          d.rdata[3:0] = q.flags; // upper bits read zero
        end
        rcf_pkg::OFS_IRQ_STAT: begin
          d.rdata[3:0] = q.irqStat;
        end
        rcf_pkg::OFS_IRQ_EN: begin
          d.rdata[3:0] = q.irqEn;
        end
        rcf_pkg::OFS_WIDTH_SEL: begin
          d.rdata[1:0] = q.widthSel;
        end
        rcf_pkg::OFS_STATE: begin
          d.rdata[0]    = q.lowSync[1];
          d.rdata[1]    = monitorEn;
          d.rdata[2]    = vselBad;
          d.rdata[3]    = rctlBad;
          d.rdata[15:8] = dipCount;
        end
        default: begin
          d.rdata = 32'h0000_0000; // unmapped reads answer zero
        end
      endcase
    end else if (q.ack) begin
      d.rdata = q.rdata;
    end
  end

  // power-on reset clears every flag
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q          <= '0;
      q.flags    <= rcf_pkg::FLAGS_RST;
      q.irqEn    <= rcf_pkg::IRQ_EN_RST;
      q.widthSel <= rcf_pkg::WIDTH_SEL_RST;
    end else begin
      q <= d;
    end
  end

  // bus answers: readdata registered, waitrequest combinational
  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = busReq && !busDone;

  // flags are visible directly to the cpu core as well
  assign resetCauseFlags = q.flags;
  assign resetRequest    = q.resetReq;

  // one level interrupt while any enabled status bit stands
  assign irq = |(q.irqStat & q.irqEn);

endmodule
`default_nettype wire

// >>> sim/rcf_reset_flags_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module rcf_reset_flags_asserts (
  // clock and reset
  input wire logic                core_clk,
  input wire logic                rst_n,
  // register bus
  input wire logic [7:0]          avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  // causes and results
  input wire logic                lowSupplyPin,
  input wire rcf_pkg::rcf_cause_t cause,
  input wire logic                resetRequest,
  input wire logic [3:0]          resetCauseFlags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0]  clrSeen_q;
  logic [15:0] lowRun_q;
  logic        vBad;
  logic        rBad;
  // codes outside the defined sets
  assign vBad = !(cause.voltageSelectCtrl inside {8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0});
  assign rBad = !(cause.resetFunctionCtrl inside {8'h55, 8'hAA});
  // clear history; the low run saturates so a long dip never wraps to look short
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clrSeen_q <= 2'h0;
      lowRun_q  <= 16'h0000;
    end else begin
      clrSeen_q <= {clrSeen_q[0], avs_write && !avs_waitrequest && avs_address == 8'h00};
      if (!lowSupplyPin) begin
        lowRun_q <= 16'h0000;
      end else if (lowRun_q != 16'hFFFF) begin
        lowRun_q <= lowRun_q + 16'h0001;
      end
    end
  end
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  wdog_set_a: assert property (cause.watchdogCorrupt |-> ##[1:2] resetCauseFlags[0])
    else $error("watchdog flag not set");
  vsel_set_a: assert property (vBad |-> ##[1:2] resetCauseFlags[1])
    else $error("voltage select flag not set");
  rctl_set_a: assert property (rBad |-> ##[1:2] resetCauseFlags[3])
    else $error("reset control flag not set");
  flag_sticky_a: assert property (|($past(resetCauseFlags) & ~resetCauseFlags) |-> |clrSeen_q)
    else $error("flag dropped without a clear");
  reset_req_a: assert property (vBad || rBad || cause.watchdogCorrupt |=> resetRequest)
    else $error("reset request missing");
  upper_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h00
    |-> avs_readdata[31:4] == 28'h0000000) else $error("upper flag bits not zero");
  dip_width_a: assert property ($rose(resetCauseFlags[2]) |-> lowRun_q >= 16'h4E20)
    else $error("short dip set low supply flag");
endmodule
bind rcf_reset_flags rcf_reset_flags_asserts u_asserts (.core_clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .lowSupplyPin, .cause, .resetRequest, .resetCauseFlags);
`default_nettype wire

// >>> sim/rcf_reset_flags_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module rcf_reset_flags_tb_top;
  logic                core_clk;
  logic                rst_n;
  logic [7:0]          avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [3:0]          avs_byteenable;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic                lowSupplyPin;
  rcf_pkg::rcf_cause_t cause;
  logic                resetRequest;
  logic [3:0]          resetCauseFlags;
  logic                irq;
  logic [31:0]         q;
  logic [7:0]          codes [12];
  int                  err_total;
  int                  checks_done;

  rcf_reset_flags DUT (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .lowSupplyPin, .cause, .resetRequest,
    .resetCauseFlags, .irq);

  // expected flag word for a code applied to both control inputs
  function automatic logic [31:0] expFlags(input logic [7:0] v);
    logic vb;
    logic rb;
    vb = !(v inside {8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0});
    rb = !(v inside {8'h55, 8'hAA});
    return {28'h0000000, rb, 1'b0, vb, 1'b0};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= !w;
    avs_write      <= w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, 4'hF);
    chk(q, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // free-running 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // hang guard, well above the two dip runs
  initial begin
    repeat (90000) @(posedge core_clk);
    err_total++;
    wrap_up;
  end

  // main sequence
  initial begin
    err_total = 0;
    checks_done = 0;
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    lowSupplyPin = 1'b0;
    cause = '{8'h66, 8'h55, 1'b0};
    void'($urandom(15265));
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h00000000);
    rd(8'h10, 32'h00000001);
    rd(8'h20, 32'h00000000);
    // idle state word: monitor enabled on a defined code, no dip counted
    rd(8'h14, 32'h00000002);
    // watchdog corruption pulse, then interrupt masked, enabled, cleared
    @(posedge core_clk) cause.watchdogCorrupt <= 1'b1;
    @(posedge core_clk) cause.watchdogCorrupt <= 1'b0;
    rd(8'h00, 32'h00000001);
    rd(8'h04, 32'h00000001);
    @(negedge core_clk) chk({31'h00000000, irq}, 32'h00000000);
    wr(8'h08, 32'h0000000F);
    rd(8'h08, 32'h0000000F);
    @(negedge core_clk) chk({31'h00000000, irq}, 32'h00000001);
    wr(8'h0C, 32'h0000000F);
    rd(8'h04, 32'h00000000);
    @(negedge core_clk) chk({31'h00000000, irq}, 32'h00000000);
    // clears without byte enable or with ones leave the flag alone
    bus(1'b1, 8'h00, 32'h00000000, 4'h0);
    rd(8'h00, 32'h00000001);
    wr(8'h00, 32'h000000FF);
    rd(8'h00, 32'h00000001);
    wr(8'h00, 32'h00000000);
    rd(8'h00, 32'h00000000);
    // all defined codes, corner codes and random codes; flags outlive the bad code
    codes = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 8; i < 12; i++) begin
      codes[i] = 8'($urandom);
    end
    foreach (codes[i]) begin
      @(posedge core_clk);
      cause.voltageSelectCtrl <= codes[i];
      cause.resetFunctionCtrl <= codes[i];
      repeat (2) @(posedge core_clk);
      cause <= '{8'h66, 8'h55, 1'b0};
      rd(8'h00, expFlags(codes[i]));
      wr(8'h00, 32'h00000000);
    end
    // short dip is ignored, long dip sets the sticky flag
    wr(8'h10, 32'h00000000);
    rd(8'h10, 32'h00000000);
    lowSupplyPin <= 1'b1;
    repeat (3 * 3125) @(posedge core_clk);
    lowSupplyPin <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd(8'h00, 32'h00000000);
    lowSupplyPin <= 1'b1;
    repeat (10 * 3125) @(posedge core_clk);
    lowSupplyPin <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd(8'h00, 32'h00000004);
    wr(8'h00, 32'h00000000);
    rd(8'h00, 32'h00000000);
    // power-on reset in mid-run clears a standing flag and returns the width select to its reset value of 1
    @(posedge core_clk) cause.watchdogCorrupt <= 1'b1;
    @(posedge core_clk) cause.watchdogCorrupt <= 1'b0;
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h00000000);
    rd(8'h10, 32'h00000001);
    wrap_up;
  end
endmodule
`default_nettype wire
